// ===== core/dsrs_pkg.sv
// constants, register map and state encoding of the slot reset sequencer
package dsrs_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int MIN_RST_NS = 200000;
  // least time, so round up
  localparam int MIN_RST_CYC = (MIN_RST_NS + CLK_PERIOD_NS - 1) /
                               CLK_PERIOD_NS;
  localparam int PRESC_NS = 1000;
  localparam int PRESC_CYC = (PRESC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_HPCFG = 8'h00;
  localparam logic [7:0] OFS_SCTL = 8'h04;
  localparam logic [7:0] OFS_PFUNC = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int MODE_LSB = 0;
  localparam int P2R_LSB = 8;
  localparam int R2P_LSB = 16;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [7:0] P2R_RST = 8'h0a;
  localparam logic [7:0] R2P_RST = 8'h0a;
  localparam logic SCTL_RST = 1'h1;
  localparam logic PFUNC_RST = 1'h0;
  localparam int CTL_BIT = 0;
  localparam int STAT_RST_BIT = 0;
  localparam int STAT_PWR_BIT = 1;
  localparam int STAT_PG_BIT = 2;
  localparam int STAT_ST_LSB = 4;
  localparam int IRQ_W = 3;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_UP = 1;
  localparam int IRQ_DOWN = 2;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    DSRS_MODE_PEN = 2'h0,
    DSRS_MODE_PG = 2'h1,
    DSRS_MODE_HOT = 2'h2
  } dsrs_mode_e;

  typedef enum logic [2:0] {
    DSRS_OFF = 3'h0,
    DSRS_PGWAIT = 3'h1,
    DSRS_P2R = 3'h2,
    DSRS_ON = 3'h3,
    DSRS_R2P = 3'h4,
    DSRS_HOT = 3'h5
  } dsrs_state_e;
endpackage : dsrs_pkg

// ===== core/dsrs_sequencer.sv
// downstream slot reset and power sequencer with ahb-lite registers
`timescale 1ns/100ps
module dsrs_sequencer #(
  parameter int MIN_RST_CYC = dsrs_pkg::MIN_RST_CYC
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic slot_power_good_in_n,
  input wire logic hot_reset_active,
  output logic slot_reset_out_n,
  output logic slot_reset_oe_n,
  output logic slot_power_enable_out,
  output logic irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic [1:0] mode;
    logic [7:0] p2r;
    logic [7:0] r2p;
    logic slot_power_off_ctl;
    logic alt_sel;
    logic [dsrs_pkg::IRQ_W-1:0] irq_stat;
    logic [dsrs_pkg::IRQ_W-1:0] irq_mask;
    dsrs_pkg::dsrs_state_e st;
    logic rst_on;
    logic pwr_on;
    logic [dsrs_pkg::CNT_W-1:0] dly;
    logic [dsrs_pkg::CNT_W-1:0] mcnt;
  } dsrs_regs_s;

  dsrs_regs_s r;
  dsrs_regs_s next_r;

  logic addr_ok;
  logic pg_ok;
  logic min_ok;
  logic pg_mode;
  logic [31:0] rd_val;
  logic [dsrs_pkg::IRQ_W-1:0] ev;
  logic [dsrs_pkg::CNT_W-1:0] p2r_cyc;
  logic [dsrs_pkg::CNT_W-1:0] r2p_cyc;

  assign addr_ok = hsel && hready && htrans == dsrs_pkg::HTRANS_NONSEQ;
  // taken as synchronous; a raw pin needs a synchroniser first
  assign pg_ok = !slot_power_good_in_n;
  assign pg_mode = r.mode == dsrs_pkg::DSRS_MODE_PG;
  assign min_ok = int'(r.mcnt) >= MIN_RST_CYC - 1;
  // delays count prescaled ticks of core clock
  assign p2r_cyc = dsrs_pkg::CNT_W'(int'(r.p2r) * dsrs_pkg::PRESC_CYC);
  assign r2p_cyc = dsrs_pkg::CNT_W'(int'(r.r2p) * dsrs_pkg::PRESC_CYC);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 32'h0;
    case (haddr)
      dsrs_pkg::OFS_HPCFG: begin
        rd_val[dsrs_pkg::MODE_LSB +: 2] = r.mode;
        rd_val[dsrs_pkg::P2R_LSB +: 8] = r.p2r;
        rd_val[dsrs_pkg::R2P_LSB +: 8] = r.r2p;
      end
      dsrs_pkg::OFS_SCTL: rd_val[dsrs_pkg::CTL_BIT] = r.slot_power_off_ctl;
      dsrs_pkg::OFS_PFUNC: rd_val[dsrs_pkg::CTL_BIT] = r.alt_sel;
      dsrs_pkg::OFS_STAT: begin
        rd_val[dsrs_pkg::STAT_RST_BIT] = r.rst_on;
        rd_val[dsrs_pkg::STAT_PWR_BIT] = r.pwr_on;
        rd_val[dsrs_pkg::STAT_PG_BIT] = pg_ok;
        rd_val[dsrs_pkg::STAT_ST_LSB +: 3] = r.st;
      end
      dsrs_pkg::OFS_IRQ: rd_val[dsrs_pkg::IRQ_W-1:0] = r.irq_stat;
      dsrs_pkg::OFS_MASK: rd_val[dsrs_pkg::IRQ_W-1:0] = r.irq_mask;
      default: rd_val = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    ev = '0;
    // --------------------------------------------------------------
    // bus: capture address phase, write in data phase
    // --------------------------------------------------------------
    next_r.wr_pend = addr_ok && hwrite;
    if (addr_ok) begin
      next_r.wr_addr = haddr;
    end
    if (addr_ok && !hwrite) begin
      next_r.rdata = rd_val;
    end
    if (r.wr_pend) begin
      case (r.wr_addr)
        dsrs_pkg::OFS_HPCFG: begin
          next_r.mode = hwdata[dsrs_pkg::MODE_LSB +: 2];
          next_r.p2r = hwdata[dsrs_pkg::P2R_LSB +: 8];
          next_r.r2p = hwdata[dsrs_pkg::R2P_LSB +: 8];
        end
        dsrs_pkg::OFS_SCTL: begin
          next_r.slot_power_off_ctl = hwdata[dsrs_pkg::CTL_BIT];
        end
        dsrs_pkg::OFS_PFUNC: begin
          next_r.alt_sel = hwdata[dsrs_pkg::CTL_BIT];
        end
        dsrs_pkg::OFS_IRQ: next_r.irq_stat = r.irq_stat &
                             ~hwdata[dsrs_pkg::IRQ_W-1:0];
        dsrs_pkg::OFS_MASK: next_r.irq_mask = hwdata[dsrs_pkg::IRQ_W-1:0];
        default: next_r.mode = r.mode;
      endcase
    end

    // --------------------------------------------------------------
    // counters
    // --------------------------------------------------------------
    // minimum pulse counter runs while reset is asserted
    // saturates, so a long reset never wraps into a short pulse
    if (!r.rst_on) begin
      next_r.mcnt = '0;
    end else if (!min_ok) begin
      next_r.mcnt = r.mcnt + 1'b1;
    end
    if (r.dly != '0) begin
      next_r.dly = r.dly - 1'b1;
    end

    // --------------------------------------------------------------
    // slot sequencing
    // --------------------------------------------------------------
    case (r.st)
      dsrs_pkg::DSRS_OFF: begin
        // power first; release waits for the delay, in pg mode for power good then the delay, in hot mode only for hot reset to end and the minimum width
        next_r.rst_on = 1'b1;
        next_r.pwr_on = 1'b0;
        if (!r.slot_power_off_ctl) begin
          next_r.pwr_on = 1'b1;
          next_r.dly = p2r_cyc;
          if (r.mode == dsrs_pkg::DSRS_MODE_HOT) begin
            next_r.st = dsrs_pkg::DSRS_HOT;
          end else if (pg_mode) begin
            next_r.st = dsrs_pkg::DSRS_PGWAIT;
          end else begin
            next_r.st = dsrs_pkg::DSRS_P2R;
          end
        end
      end
      dsrs_pkg::DSRS_PGWAIT: begin
        // no timeout: a slot never reporting good stays in reset
        if (r.slot_power_off_ctl) begin
          next_r.dly = r2p_cyc;
          next_r.st = dsrs_pkg::DSRS_R2P;
        end else if (pg_ok) begin
          next_r.dly = p2r_cyc;
          next_r.st = dsrs_pkg::DSRS_P2R;
        end
      end
      dsrs_pkg::DSRS_P2R: begin
        if (r.slot_power_off_ctl) begin
          next_r.dly = r2p_cyc;
          next_r.st = dsrs_pkg::DSRS_R2P;
        end else if (pg_mode && !pg_ok) begin
          next_r.st = dsrs_pkg::DSRS_PGWAIT;
        end else if (r.dly == '0 && min_ok) begin
          next_r.rst_on = 1'b0;
          ev[dsrs_pkg::IRQ_UP] = 1'b1;
          next_r.st = dsrs_pkg::DSRS_ON;
        end
      end
      dsrs_pkg::DSRS_ON: begin // negated while powered
        if (r.slot_power_off_ctl) begin
          next_r.rst_on = 1'b1;
          next_r.dly = r2p_cyc;
          next_r.st = dsrs_pkg::DSRS_R2P;
        end else if (pg_mode && !pg_ok) begin
          next_r.rst_on = 1'b1;
          ev[dsrs_pkg::IRQ_FAULT] = 1'b1;
          next_r.st = dsrs_pkg::DSRS_PGWAIT;
        end
      end
      dsrs_pkg::DSRS_R2P: begin
        // reset held through the whole ramp-down
        next_r.rst_on = 1'b1;
        if (r.dly == '0) begin
          next_r.pwr_on = 1'b0;
          ev[dsrs_pkg::IRQ_DOWN] = 1'b1;
          next_r.st = dsrs_pkg::DSRS_OFF;
        end
      end
      dsrs_pkg::DSRS_HOT: begin
        if (r.slot_power_off_ctl) begin
          next_r.rst_on = 1'b1;
          next_r.dly = r2p_cyc;
          next_r.st = dsrs_pkg::DSRS_R2P;
        end else if (hot_reset_active) begin
          next_r.rst_on = 1'b1;
        end else if (r.rst_on && min_ok) begin
          // hot reset over and minimum width served
          next_r.rst_on = 1'b0;
          ev[dsrs_pkg::IRQ_UP] = 1'b1;
        end
      end
      default: next_r.st = dsrs_pkg::DSRS_OFF;
    endcase

    // --------------------------------------------------------------
    // pin function override
    // --------------------------------------------------------------
    // general purpose use parks the sequencer, slot unpowered
    // power dropped the next cycle, so a card runs at most one cycle with reset floating
    if (!r.alt_sel) begin
      next_r.st = dsrs_pkg::DSRS_OFF;
      next_r.rst_on = 1'b1;
      next_r.pwr_on = 1'b0;
      ev = '0;
    end
    // a new event beats a same-cycle clear
    next_r.irq_stat = next_r.irq_stat | ev;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      r <= '0;
      r.mode <= dsrs_pkg::MODE_RST;
      r.p2r <= dsrs_pkg::P2R_RST;
      r.r2p <= dsrs_pkg::R2P_RST;
      r.slot_power_off_ctl <= dsrs_pkg::SCTL_RST;
      r.alt_sel <= dsrs_pkg::PFUNC_RST;
      r.st <= dsrs_pkg::DSRS_OFF;
      r.rst_on <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // taken at address phase, so a read right behind a write is stale
  assign hrdata = r.rdata;
  // zero wait states: every register answers in one cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign slot_reset_out_n = !r.rst_on;
  assign slot_reset_oe_n = !r.alt_sel;
  assign slot_power_enable_out = r.pwr_on;
  assign irq = |(r.irq_stat & r.irq_mask);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_min_pulse: assert property (
    $fell(r.rst_on) |-> int'($past(r.mcnt)) >= MIN_RST_CYC - 1)
    else $error("slot reset released too early");
  a_pin_gpio: assert property (
    !r.alt_sel |-> slot_reset_oe_n ##1 !slot_power_enable_out)
    else $error("pin driven in general purpose use");
  a_reset_float: assert property (
    $past(srst) |-> slot_reset_oe_n && !slot_reset_out_n)
    else $error("pin driven after reset");
  a_power_off: assert property (
    !slot_power_enable_out |-> !slot_reset_out_n)
    else $error("reset negated without power");
  a_power_first: assert property (
    $fell(r.rst_on) && $past(r.st) == dsrs_pkg::DSRS_P2R
    |-> $past(r.pwr_on) && $past(r.dly) == '0)
    else $error("reset released before power delay");
  a_on_held: assert property (
    r.st == dsrs_pkg::DSRS_ON && !r.slot_power_off_ctl && r.alt_sel &&
    !(pg_mode && !pg_ok) |=> !r.rst_on)
    else $error("reset asserted while powered");
  a_reset_first: assert property (
    $fell(r.pwr_on) && r.alt_sel |-> $past(r.rst_on) &&
    $past(r.st) == dsrs_pkg::DSRS_R2P && $past(r.dly) == '0)
    else $error("power dropped before reset");
  a_pg_release: assert property (
    $fell(r.rst_on) && pg_mode |-> $past(pg_ok))
    else $error("release without power good");
  a_pg_fault: assert property (
    r.st == dsrs_pkg::DSRS_ON && pg_mode && !pg_ok |=> r.rst_on)
    else $error("power fault not acted on");
  a_power_ctl: assert property (
    r.st == dsrs_pkg::DSRS_OFF && r.alt_sel && !r.slot_power_off_ctl
    |=> r.pwr_on)
    else $error("power not switched on");
  a_hot_follow: assert property (
    r.st == dsrs_pkg::DSRS_HOT && hot_reset_active && r.alt_sel
    && !r.slot_power_off_ctl |=> r.rst_on)
    else $error("hot reset not propagated");
  // ----------------------------------------------------------------
  // state checks
  // ----------------------------------------------------------------
  a_r2p_reset: assert property (
    r.st == dsrs_pkg::DSRS_R2P |-> r.rst_on)
    else $error("reset negated during power down");
  a_pg_wait: assert property (
    r.st == dsrs_pkg::DSRS_PGWAIT |-> r.rst_on && r.pwr_on)
    else $error("reset or power wrong while awaiting good");
  a_hot_release: assert property (
    $fell(r.rst_on) && $past(r.st) == dsrs_pkg::DSRS_HOT
    |-> !$past(hot_reset_active))
    else $error("reset released during hot reset");
  a_fault_flag: assert property (
    r.st == dsrs_pkg::DSRS_ON && pg_mode && !pg_ok && r.alt_sel &&
    !r.slot_power_off_ctl |=> r.irq_stat[dsrs_pkg::IRQ_FAULT])
    else $error("power fault not flagged");

  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  c_pen_up: cover property ($fell(r.rst_on) &&
    r.mode == dsrs_pkg::DSRS_MODE_PEN);
  c_pg_fault: cover property (r.st == dsrs_pkg::DSRS_ON && pg_mode && !pg_ok);
  c_hot_cycle: cover property ($fell(r.rst_on) &&
    r.mode == dsrs_pkg::DSRS_MODE_HOT);
  c_power_down: cover property ($fell(r.pwr_on) && r.alt_sel);
  c_pg_wait: cover property (r.st == dsrs_pkg::DSRS_PGWAIT && pg_ok);
endmodule : dsrs_sequencer

// ===== sim/dsrs_slot_model.sv
// slot power switch model: power good follows enable after a ramp
`timescale 1ns/100ps
module dsrs_slot_model #(
  parameter int RAMP_CYC = 30
) (
  input wire logic ref_clk,
  input wire logic power_en,
  input wire logic fault,
  output logic power_good_n
);
  // ----------------------------------------
  // supply ramp
  // ----------------------------------------
  int ramp = 0;
  initial power_good_n = 1'b1;
  always @(posedge ref_clk) begin
    if (!power_en || fault) ramp <= 0;
    else if (ramp < RAMP_CYC) ramp <= ramp + 1;
    // not good while off, ramping or faulted
    power_good_n <= !(power_en && !fault && ramp == RAMP_CYC);
  end
endmodule : dsrs_slot_model

// ===== sim/tb.sv
// testbench of the slot reset sequencer
`timescale 1ns/100ps
module tb;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic ref_clk, srst, hsel, hwrite, hot, fail, pg_n, rst_n, oe_n, pen, irq;
  logic hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, q;
  int num_errors = 0;
  int checks = 0;
  int n;
  int lo;
  dsrs_sequencer #(.MIN_RST_CYC(20)) dut_u (.ref_clk(ref_clk), .srst(srst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .slot_power_good_in_n(pg_n),
    .hot_reset_active(hot), .slot_reset_out_n(rst_n),
    .slot_reset_oe_n(oe_n), .slot_power_enable_out(pen), .irq(irq));
  dsrs_slot_model slot_u (.ref_clk(ref_clk), .power_en(pen), .fault(fail),
    .power_good_n(pg_n));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(inout int c);
    @(posedge ref_clk);
    c++;
    if (c > 3000) begin
      num_errors++;
      $display("BAD wait expected done seen timeout");
      conclude();
    end
  endtask : tick
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int c;
    c = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= dsrs_pkg::HTRANS_NONSEQ;
    do tick(c); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do tick(c); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  // cycles until rst_n (sel 0) or pen (sel 1) reaches v
  task automatic wt(input bit sel, input logic v, output int c);
    c = 0;
    while ((sel ? pen : rst_n) !== v) tick(c);
  endtask : wt
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    srst = 1'b1;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hot = 1'b0;
    fail = 1'b0;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    chk("oe_n", 1, oe_n);
    chk("rst_n", 0, rst_n);
    chk("hresp", 0, hresp);
    bus(dsrs_pkg::OFS_HPCFG, 0, 0);
    chk("hpcfg", 32'h000a0a00, q);
    bus(dsrs_pkg::OFS_SCTL, 0, 0);
    chk("sctl", 1, q);
    bus(8'h18, 1, 32'hffffffff);
    bus(8'h18, 0, 0);
    chk("unmapped", 0, q);
    bus(dsrs_pkg::OFS_SCTL, 1, 0);
    repeat (60) @(posedge ref_clk);
    chk("pen gp", 0, pen);
    chk("oe_n gp", 1, oe_n);
    bus(dsrs_pkg::OFS_SCTL, 1, 1);
    $display("general purpose test done");
    for (int m = 0; m < 2; m++) begin
      bus(dsrs_pkg::OFS_HPCFG, 1, 32'h00010100 | m);
      bus(dsrs_pkg::OFS_PFUNC, 1, 1);
      bus(dsrs_pkg::OFS_MASK, 1, 7);
      chk("oe_n alt", 0, oe_n);
      bus(dsrs_pkg::OFS_SCTL, 1, 0);
      wt(1, 1, n);
      wt(0, 1, n);
      lo = m ? 55 : 25;
      chk("p2r", 1, 32'(n >= lo && n <= lo + 10));
      repeat (30) @(posedge ref_clk);
      chk("on", 1, rst_n);
      chk("irq", 1, irq);
      bus(dsrs_pkg::OFS_IRQ, 1, 7);
      @(posedge ref_clk);
      chk("irq clr", 0, irq);
      bus(dsrs_pkg::OFS_SCTL, 1, 1);
      wt(0, 0, n);
      chk("off rst", 1, 32'(n <= 3));
      wt(1, 0, n);
      chk("r2p", 1, 32'(n >= 25 && n <= 30));
      chk("off", 0, rst_n);
      $display("mode %0d test done", m);
    end
    // power fault while released
    bus(dsrs_pkg::OFS_SCTL, 1, 0);
    wt(0, 1, n);
    fail <= 1'b1;
    wt(0, 0, n);
    chk("fault", 1, 32'(n <= 3));
    bus(dsrs_pkg::OFS_IRQ, 0, 0);
    chk("fault irq", 1, q & 32'h1);
    fail <= 1'b0;
    bus(dsrs_pkg::OFS_SCTL, 1, 1);
    wt(1, 0, n);
    $display("fault test done");
    // hot reset mode, one cycle pulse
    bus(dsrs_pkg::OFS_HPCFG, 1, 32'h00010102);
    bus(dsrs_pkg::OFS_SCTL, 1, 0);
    wt(0, 1, n);
    hot <= 1'b1;
    @(posedge ref_clk);
    hot <= 1'b0;
    wt(0, 0, n);
    chk("hot", 1, 32'(n <= 3));
    wt(0, 1, n);
    chk("width", 1, 32'(n >= 19));
    bus(dsrs_pkg::OFS_PFUNC, 1, 0);
    @(posedge ref_clk);
    chk("oe_n end", 1, oe_n);
    $display("hot reset test done");
    conclude();
  end
endmodule : tb
